/* dv/pmc_macrocell_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pmc_macrocell_properties #(
  parameter int NUM_CELLS = 8,
  parameter int NUM_TERMS = 8
) (
  // clock and bus
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // array and pins
  input wire logic [NUM_CELLS*NUM_TERMS-1:0] product_terms,
  input wire logic dev_oe_n_pin,
  input wire logic [NUM_CELLS-1:0] feedback,
  input wire logic [1:0] ctrl_pin_to_array,
  input wire logic ctrl_pins_valid,
  input wire logic [NUM_CELLS-1:0] io_out,
  input wire logic [NUM_CELLS-1:0] io_oe
);
  // ---------------------------------------------------------------
  // shadow of configuration
  // ---------------------------------------------------------------
  logic acc, wr, sec;
  logic [18:0] st_q, st_d;
  logic [1:0] glb;
  logic [7:0] mode, pol;
  assign acc = psel && penable && clk_en;
  assign wr = acc && pwrite;
  assign {sec, glb, mode, pol} = st_q;
  always_comb begin
    st_d = st_q;
    if (wr && paddr == pmc_pkg::ADDR_GLOBAL) st_d[17:16] = pwdata[1:0];
    if (wr && paddr == pmc_pkg::ADDR_MODE) st_d[15:8] = pwdata[7:0];
    if (wr && paddr == pmc_pkg::ADDR_POL) st_d[7:0] = pwdata[7:0];
    if (wr && paddr == pmc_pkg::ADDR_SECURE && pwdata[0]) st_d[18] = 1'h1;
    if (wr && paddr == pmc_pkg::ADDR_ERASE && pwdata[0]) st_d = 19'h0;
  end
  always_ff @(posedge mclk) begin
    if (srst) st_q <= 19'h0;
    else st_q <= st_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_ctrl_hidden: assert property (
    !ctrl_pins_valid |-> ctrl_pin_to_array == 2'h0) else $error("ctrl pins");
  a_reset_idle: assert property (
    $fell(srst) |-> io_oe == 8'h0 && io_out == 8'h0 && feedback == 8'h0)
    else $error("reset pins");
  a_input_off: assert property (
    glb == 2'h1 && mode == 8'hFF |-> io_oe == 8'h00) else $error("input oe");
  a_io_term_oe: assert property (
    glb[1] && mode == 8'hFF |-> io_oe[0] == product_terms[7])
    else $error("term oe");
  a_reg_oe_pin: assert property (
    glb == 2'h2 && mode == 8'h00 |-> io_oe == {8{!dev_oe_n_pin}})
    else $error("reg oe");
  a_comb_polarity: assert property (
    glb == 2'h1 && mode == 8'h00 |-> io_oe == 8'hFF &&
    io_out[0] == ((|product_terms[7:0]) ^ pol[0])) else $error("comb out");
  a_secure_refuse: assert property (
    sec && acc && !pwrite && paddr == pmc_pkg::ADDR_READBACK |-> pslverr)
    else $error("readback open");
  a_secure_sticky: assert property (
    acc && !pwrite && paddr == pmc_pkg::ADDR_STATUS |-> prdata[1] == sec)
    else $error("secure state");
endmodule : pmc_macrocell_properties
bind pmc_macrocell pmc_macrocell_properties #(.NUM_CELLS(NUM_CELLS),
  .NUM_TERMS(NUM_TERMS)) u_props (.mclk, .srst, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .product_terms,
  .dev_oe_n_pin, .feedback, .ctrl_pin_to_array, .ctrl_pins_valid, .io_out,
  .io_oe);
`default_nettype wire

/* dv/pmc_macrocell_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pmc_macrocell_tb;
  logic mclk, srst, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic dev_clk_pin, dev_oe_n_pin, ctrl_pins_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pattern_word, rd;
  logic [63:0] product_terms;
  logic [1:0] ctrl_pin_to_array;
  logic [7:0] feedback, io_in, io_out, io_oe;
  int bad_count, tests_run, cycles;
  pmc_macrocell dut (.mclk, .srst, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .product_terms,
    .pattern_word, .dev_clk_pin, .dev_oe_n_pin, .feedback,
    .ctrl_pin_to_array, .ctrl_pins_valid, .io_in, .io_out, .io_oe);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rc(pmc_pkg::ADDR_STATUS, 32'h1);
    rc(pmc_pkg::ADDR_PRELOAD, 32'h0);
  endtask : t_reset
  task automatic t_comb();
    wr(pmc_pkg::ADDR_POL, 32'h0F);
    wr(pmc_pkg::ADDR_GLOBAL, 32'h1);
    chk(io_out, 8'hDA);
    chk(feedback, 8'hC2);
    chk(ctrl_pin_to_array, 2'h2);
    chk(ctrl_pins_valid, 1'b1);
  endtask : t_comb
  task automatic t_io();
    wr(pmc_pkg::ADDR_MODE, 32'hFF);
    chk(io_oe, 8'h00);
    chk(feedback, 8'h2D);
    wr(pmc_pkg::ADDR_GLOBAL, 32'h3);
    chk(io_oe, 8'h84);
    chk(io_out, 8'h5A);
    chk(feedback, 8'h96);
    wr(pmc_pkg::ADDR_GLOBAL, 32'h2);
    chk(io_oe, 8'h84);
    chk(feedback, 8'h96);
    chk(ctrl_pin_to_array, 2'h0);
    chk(ctrl_pins_valid, 1'b0);
  endtask : t_io
  task automatic t_reg();
    wr(pmc_pkg::ADDR_MODE, 32'h0);
    wr(pmc_pkg::ADDR_PRELOAD, 32'hA5);
    chk(io_out, 8'h5A);
    chk(feedback, 8'h5A);
    chk(io_oe, 8'h00);
    @(posedge mclk);
    dev_oe_n_pin <= 1'b0;
    dev_clk_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(io_oe, 8'hFF);
    rc(pmc_pkg::ADDR_PRELOAD, 32'hDA);
    dev_clk_pin <= 1'b0;
  endtask : t_reg
  task automatic t_sec();
    rc(pmc_pkg::ADDR_READBACK, 32'h12345678);
    chk(err, 1'b0);
    wr(pmc_pkg::ADDR_SIG_LO, 32'hCAFE0001);
    wr(pmc_pkg::ADDR_SIG_HI, 32'h80000002);
    wr(pmc_pkg::ADDR_SECURE, 32'h1);
    apb(1'b0, pmc_pkg::ADDR_READBACK, 32'h0);
    chk(err, 1'b1);
    wr(pmc_pkg::ADDR_SECURE, 32'h0);
    rc(pmc_pkg::ADDR_STATUS, 32'h2);
    rc(pmc_pkg::ADDR_SIG_LO, 32'hCAFE0001);
    rc(pmc_pkg::ADDR_SIG_HI, 32'h80000002);
    chk(err, 1'b0);
    wr(pmc_pkg::ADDR_ERASE, 32'h1);
    rc(pmc_pkg::ADDR_STATUS, 32'h1);
    rc(pmc_pkg::ADDR_SIG_HI, 32'h80000002);
    apb(1'b0, 12'h030, 32'h0);
    chk(err, 1'b1);
  endtask : t_sec
  // clock enable low must drop a write
  task automatic t_freeze();
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(pmc_pkg::ADDR_POL, 32'h33);
    @(posedge mclk);
    clk_en <= 1'b1;
    rc(pmc_pkg::ADDR_POL, 32'h0);
  endtask : t_freeze
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    pattern_word = 32'h12345678;
    product_terms = 64'h8001004000810_07F;
    dev_clk_pin = 1'b0;
    dev_oe_n_pin = 1'b1;
    io_in = 8'h96;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_comb();
    t_io();
    t_reg();
    t_sec();
    t_freeze();
    summarize();
  end
endmodule : pmc_macrocell_tb
`default_nettype wire

/* rtl/pmc_macrocell.sv */
// Contract
// RULE1 - globals 1,0 mode 0: combinatorial output
// RULE2 - combinatorial output: centre cells drop feedback
// RULE3 - globals 1,0 mode 1: input, neighbour feedback
// RULE4 - globals 1,1 mode 1: seven terms, eighth enables
// RULE5 - non-registered I/O: pin level feeds array
// RULE6 - globals 0,1 mode 1: registered-device I/O
// RULE7 - polarity bit XOR: 0 high, 1 low
// RULE8 - all flip-flops reset to low
// RULE9 - registered pins show inverted register
// RULE10 - registers preloadable with any state
// RULE11 - security bit blocks pattern readback
// RULE12 - security clears only with array erase
// RULE13 - 64-bit user signature word
// RULE14 - signature readable despite security bit
// RULE15 - programmer erases automatically, no command; here erase needs a write of 1 to ADDR_ERASE
// RULE16 - globals 0,1 mode 0: registered output
// RULE17 - register captures on shared clock rise
// RULE18 - registered driver enabled by shared oe_n
// RULE19 - edge cells feedback select by inverted allow
// RULE20 - unlisted combinations flagged unsupported
// RULE21 - registers allowed: clk/oe pins not array inputs
`timescale 1ns/1ps
`default_nettype none
module pmc_macrocell #(
  parameter int NUM_CELLS = pmc_pkg::NUM_CELLS,
  parameter int NUM_TERMS = pmc_pkg::NUM_TERMS
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // array side
  input wire logic [NUM_CELLS*NUM_TERMS-1:0] product_terms,
  input wire logic [31:0] pattern_word,
  input wire logic dev_clk_pin,
  input wire logic dev_oe_n_pin,
  output logic [NUM_CELLS-1:0] feedback,
  output logic [1:0] ctrl_pin_to_array,
  output logic ctrl_pins_valid,
  // i/o pins
  input wire logic [NUM_CELLS-1:0] io_in,
  output logic [NUM_CELLS-1:0] io_out,
  output logic [NUM_CELLS-1:0] io_oe
);
  // -------------------------------------------------------------------------
  // configuration state
  // -------------------------------------------------------------------------
  pmc_pkg::pmc_global_type glb_q, glb_d;
  logic [NUM_CELLS-1:0] mode_q, mode_d;
  logic [NUM_CELLS-1:0] pol_q, pol_d;
  logic [63:0] sig_q, sig_d;
  logic secure_q, secure_d;
  logic [NUM_CELLS-1:0] ff_q, ff_d;
  logic clk_pin_q, clk_pin_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  pmc_pkg::pmc_mode_type cell_mode [NUM_CELLS];
  pmc_pkg::pmc_pins_type pins;
  logic [NUM_CELLS-1:0] sop;
  logic [NUM_CELLS-1:0] unsup;
  logic wr_en, rd_en, clk_rise;

  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & penable & ~pwrite & clk_en;
  assign clk_rise = dev_clk_pin & ~clk_pin_q;

  // -------------------------------------------------------------------------
  // per-cell datapath
  // -------------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    localparam int NB = (c == 0) ? 1 : c - 1;
    logic [NUM_TERMS-1:0] pt;
    logic fb_sel;
    assign pt = product_terms[c*NUM_TERMS +: NUM_TERMS];
    // edge cells use the inverted allow bit on feedback select
    assign fb_sel = (c == 0 || c == NUM_CELLS - 1) ?
      ~glb_q.global_register_allow_bit :
      glb_q.global_emulation_select_bit; // RULE19
    always_comb begin
      case ({glb_q.global_register_allow_bit,
             glb_q.global_emulation_select_bit, mode_q[c]})
        3'h2: cell_mode[c] = pmc_pkg::PMC_REGISTERED; // RULE16
        3'h3: cell_mode[c] = pmc_pkg::PMC_COMB_IO_REG; // RULE6
        3'h4: cell_mode[c] = pmc_pkg::PMC_COMB_OUT; // RULE1
        3'h5: cell_mode[c] = pmc_pkg::PMC_DED_INPUT; // RULE3
        3'h7: cell_mode[c] = pmc_pkg::PMC_COMB_IO; // RULE4
        default: cell_mode[c] = pmc_pkg::PMC_UNSUPPORTED; // RULE20
      endcase
    end
    always_comb begin
      unsup[c] = 1'b0;
      sop[c] = |pt;
      pins.out[c] = 1'b0;
      pins.oe[c] = 1'b0;
      feedback[c] = 1'b0;
      case (cell_mode[c])
        pmc_pkg::PMC_REGISTERED: begin
          sop[c] = |pt;
          pins.out[c] = ~ff_q[c]; // RULE9
          pins.oe[c] = ~dev_oe_n_pin; // RULE18
          feedback[c] = fb_sel ? ~ff_q[c] : io_in[c];
        end
        pmc_pkg::PMC_COMB_OUT: begin
          sop[c] = |pt;
          pins.out[c] = sop[c] ^ pol_q[c]; // RULE7
          pins.oe[c] = 1'b1;
          // centre cells have no feedback here
          feedback[c] = (c == pmc_pkg::CENTRE_LO ||
                         c == pmc_pkg::CENTRE_HI) ? 1'b0 :
                        pins.out[c]; // RULE2
        end
        pmc_pkg::PMC_DED_INPUT: begin
          pins.oe[c] = 1'b0; // RULE3
          feedback[c] = io_in[NB]; // RULE3
        end
        pmc_pkg::PMC_COMB_IO, pmc_pkg::PMC_COMB_IO_REG: begin
          sop[c] = |pt[NUM_TERMS-2:0]; // RULE4
          pins.out[c] = sop[c] ^ pol_q[c]; // RULE7
          pins.oe[c] = pt[NUM_TERMS-1]; // RULE4 RULE6
          feedback[c] = io_in[c]; // RULE5 RULE6
        end
        default: begin
          unsup[c] = 1'b1; // RULE20
        end
      endcase
    end
    always_comb begin
      ff_d[c] = ff_q[c];
      if (wr_en && paddr == pmc_pkg::ADDR_PRELOAD) begin
        ff_d[c] = pwdata[c]; // RULE10
      end else if (clk_rise &&
                   cell_mode[c] == pmc_pkg::PMC_REGISTERED) begin
        ff_d[c] = sop[c] ^ pol_q[c]; // RULE17 RULE7
      end
    end
  end

  assign io_out = pins.out;
  assign io_oe = pins.oe;
  // control pins reach the array only without registers
  assign ctrl_pins_valid = glb_q.global_register_allow_bit; // RULE21
  assign ctrl_pin_to_array = glb_q.global_register_allow_bit ?
    {dev_oe_n_pin, dev_clk_pin} : 2'h0; // RULE21

  // -------------------------------------------------------------------------
  // register next state
  // -------------------------------------------------------------------------
  always_comb begin
    glb_d = glb_q;
    mode_d = mode_q;
    pol_d = pol_q;
    sig_d = sig_q;
    secure_d = secure_q;
    clk_pin_d = dev_clk_pin;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (wr_en) begin
      case (paddr)
        pmc_pkg::ADDR_GLOBAL: begin
          glb_d.global_register_allow_bit = pwdata[pmc_pkg::GLB_REG_ALLOW];
          glb_d.global_emulation_select_bit = pwdata[pmc_pkg::GLB_EMUL];
        end
        pmc_pkg::ADDR_MODE: mode_d = pwdata[NUM_CELLS-1:0];
        pmc_pkg::ADDR_POL: pol_d = pwdata[NUM_CELLS-1:0];
        pmc_pkg::ADDR_PRELOAD: pslverr_d = 1'b0;
        pmc_pkg::ADDR_SIG_LO: sig_d[31:0] = pwdata; // RULE13
        pmc_pkg::ADDR_SIG_HI: sig_d[63:32] = pwdata; // RULE13
        pmc_pkg::ADDR_SECURE: begin
          // set only; no clear path here
          if (pwdata[0]) begin
            secure_d = 1'b1; // RULE12
          end
        end
        pmc_pkg::ADDR_ERASE: begin
          // erase clears globals, mode and polarity with the security bit; signature and registers are kept
          if (pwdata[0]) begin
            secure_d = pmc_pkg::REG_RST; // RULE12 RULE15
            glb_d = pmc_pkg::CFG_RST;
            mode_d = pmc_pkg::CELL_RST;
            pol_d = pmc_pkg::CELL_RST;
          end
        end
        default: pslverr_d = 1'b1;
      endcase
    end else if (rd_en) begin
      prdata_d = 32'h00000000;
      case (paddr)
        pmc_pkg::ADDR_GLOBAL: prdata_d[1:0] = glb_q;
        pmc_pkg::ADDR_MODE: prdata_d[NUM_CELLS-1:0] = mode_q;
        pmc_pkg::ADDR_POL: prdata_d[NUM_CELLS-1:0] = pol_q;
        pmc_pkg::ADDR_STATUS: begin
          prdata_d[pmc_pkg::STS_UNSUP] = |unsup;
          prdata_d[pmc_pkg::STS_SECURE] = secure_q;
        end
        pmc_pkg::ADDR_PRELOAD: prdata_d[NUM_CELLS-1:0] = ff_q;
        pmc_pkg::ADDR_SIG_LO: prdata_d = sig_q[31:0]; // RULE14
        pmc_pkg::ADDR_SIG_HI: prdata_d = sig_q[63:32]; // RULE14
        pmc_pkg::ADDR_SECURE: prdata_d[0] = secure_q;
        pmc_pkg::ADDR_ERASE: prdata_d = 32'h00000000;
        pmc_pkg::ADDR_READBACK: begin
          if (secure_q) begin
            pslverr_d = 1'b1; // RULE11
          end else begin
            prdata_d = pattern_word;
          end
        end
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      glb_q <= pmc_pkg::CFG_RST;
      mode_q <= pmc_pkg::CELL_RST;
      pol_q <= pmc_pkg::CELL_RST;
      sig_q <= pmc_pkg::SIG_RST;
      secure_q <= pmc_pkg::REG_RST;
      ff_q <= pmc_pkg::CELL_RST; // RULE8
      clk_pin_q <= pmc_pkg::REG_RST;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      glb_q <= glb_d;
      mode_q <= mode_d;
      pol_q <= pol_d;
      sig_q <= sig_d;
      secure_q <= secure_d;
      ff_q <= ff_d;
      clk_pin_q <= clk_pin_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready = psel & penable;
  assign prdata = rd_en ? prdata_d : prdata_q;
  assign pslverr = psel & penable & pslverr_d;
endmodule : pmc_macrocell
`default_nettype wire

/* rtl/pmc_pkg.sv */
package pmc_pkg;
  // -------------------------------------------------------------------------
  // sizes and reset values
  // -------------------------------------------------------------------------
  localparam int NUM_CELLS = 8;
  localparam int NUM_TERMS = 8;
  localparam int SIG_BITS = 64;
  localparam int CENTRE_LO = 3;
  localparam int CENTRE_HI = 4;
  localparam logic REG_RST = 1'h0;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [7:0] CELL_RST = 8'h00;
  localparam logic [63:0] SIG_RST = 64'h0000000000000000;

  // -------------------------------------------------------------------------
  // apb register map
  // -------------------------------------------------------------------------
  localparam logic [11:0] ADDR_GLOBAL = 12'h000;
  localparam logic [11:0] ADDR_MODE = 12'h004;
  localparam logic [11:0] ADDR_POL = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_PRELOAD = 12'h010;
  localparam logic [11:0] ADDR_SIG_LO = 12'h014;
  localparam logic [11:0] ADDR_SIG_HI = 12'h018;
  localparam logic [11:0] ADDR_SECURE = 12'h01C;
  localparam logic [11:0] ADDR_ERASE = 12'h020;
  localparam logic [11:0] ADDR_READBACK = 12'h024;
  localparam int GLB_REG_ALLOW = 0;
  localparam int GLB_EMUL = 1;
  localparam int STS_UNSUP = 0;
  localparam int STS_SECURE = 1;

  // -------------------------------------------------------------------------
  // cell modes
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PMC_REGISTERED = 3'h0,
    PMC_COMB_IO_REG = 3'h1,
    PMC_COMB_OUT = 3'h3,
    PMC_DED_INPUT = 3'h2,
    PMC_COMB_IO = 3'h6,
    PMC_UNSUPPORTED = 3'h7
  } pmc_mode_type;

  typedef struct packed {
    logic global_register_allow_bit;
    logic global_emulation_select_bit;
  } pmc_global_type;

  typedef struct packed {
    logic [NUM_CELLS-1:0] out;
    logic [NUM_CELLS-1:0] oe;
  } pmc_pins_type;
endpackage : pmc_pkg
